// file: logic/rxi_pkg.sv
package rxi_pkg;
  // register offsets on the register port
  localparam logic [7:0] RXI_ADDR_PORT_SEL = 8'h4c;
  localparam logic [7:0] RXI_ADDR_PORT_STATUS_ONE = 8'h4d;
  localparam logic [7:0] RXI_ADDR_PORT_STS2 = 8'h4e;
  localparam logic [7:0] RXI_ADDR_CAM_STS = 8'h7a;
  localparam logic [7:0] RXI_ADDR_ICR_HIGH = 8'hd8;
  localparam logic [7:0] RXI_ADDR_ICR_LOW = 8'hd9;
  localparam logic [7:0] RXI_ADDR_ISR_HIGH = 8'hda;
  localparam logic [7:0] RXI_ADDR_ISR_LOW = 8'hdb;
  localparam logic [7:0] RXI_ADDR_GPIO_STS = 8'hdc;
  localparam logic [7:0] RXI_ADDR_SEN_RISE = 8'hde;
  localparam logic [7:0] RXI_ADDR_SEN_FALL = 8'hdf;

  // reset values
  localparam logic [7:0] RXI_RST_PORT_SEL = 8'h00;
  localparam logic [7:0] RXI_RST_ICR = 8'h00;

  // writable enable bits
  localparam logic [7:0] RXI_ICR_HIGH_MASK = 8'h07;
  localparam logic [7:0] RXI_ICR_LOW_MASK = 8'h7f;

  // flag positions in the 12-bit per-port vector: low register bits 6:0, then high 4:0
  localparam int RXI_NFLAG = 12;
  localparam int RXI_F_LOCK = 0;
  localparam int RXI_F_VALID = 1;
  localparam int RXI_F_PARITY = 2;
  localparam int RXI_F_CAMERA = 3;
  localparam int RXI_F_OVERFLOW = 4;
  localparam int RXI_F_LINE_CNT = 5;
  localparam int RXI_F_LINE_LEN = 6;
  localparam int RXI_F_CRC = 7;
  localparam int RXI_F_SEQ = 8;
  localparam int RXI_F_ENC = 9;
  localparam int RXI_F_SENSOR = 10;
  localparam int RXI_F_GPIO = 11;
  localparam int RXI_LOW_W = 7;
  localparam int RXI_HIGH_W = 5;
endpackage

// file: logic/rxi_sticky_flags.sv
`timescale 1ns/100ps
module rxi_sticky_flags #(
  parameter int W = 12
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [W-1:0] i_set,
  input wire logic [W-1:0] i_clr,
  output logic [W-1:0] o_flags
);
  logic [W-1:0] flags_q;
  logic [W-1:0] flags_d;

  // hold until cleared; a set in the clear cycle wins
  assign flags_d = (flags_q & ~i_clr) | i_set; // RULE15

  // flag storage
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign o_flags = flags_q;
endmodule

// file: logic/rxi_port_int_status.sv
`timescale 1ns/100ps
// Function
// RULE1: gpio change flag, high bit 4, cleared by reading forward gpio status.
// RULE2: sensor change flag, high bit 3, cleared after both sensor edge registers read.
// RULE3: encoding error flag, high bit 2, cleared by reading port status two.
// RULE4: control sequence error flag, high bit 1, cleared by reading port status one.
// RULE5: control crc error flag, high bit 0, cleared by reading port status one.
// RULE6: line length change flag, low bit 6, cleared by reading port status two.
// RULE7: line count change flag, low bit 5, cleared by reading port status two.
// RULE8: receive overflow flag, low bit 4, cleared by reading port status two.
// RULE9: camera receiver error flag, low bit 3, cleared by reading 0x7a.
// RULE10: parity error flag, low bit 2, cleared by reading port status one.
// RULE11: port valid change flag, low bit 1, cleared by reading port status one.
// RULE12: lock change flag, low bit 0, cleared by reading port status one.
// RULE13: interrupt only where enable bit set; enables reset to zero. The gpio and sensor flags here raise the interrupt with no enable bit.
// RULE14: port select register picks which port the register port reaches.
// RULE15: flags hold until clearing read; simultaneous event keeps flag set.
module rxi_port_int_status
  import rxi_pkg::*;
#(
  parameter int NUM_PORTS = 2
) (
  input wire logic i_clk,
  input wire logic i_srst,
  // register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_hit,
  // per-port events, one-cycle pulses
  input wire logic [NUM_PORTS-1:0] i_fwd_gpio_change,
  input wire logic [NUM_PORTS-1:0] i_sensor_change,
  input wire logic [NUM_PORTS-1:0] i_link_encoding_error,
  input wire logic [NUM_PORTS-1:0] i_ctrl_sequence_error,
  input wire logic [NUM_PORTS-1:0] i_ctrl_crc_error,
  input wire logic [NUM_PORTS-1:0] i_line_length_change,
  input wire logic [NUM_PORTS-1:0] i_line_count_change,
  input wire logic [NUM_PORTS-1:0] i_rx_overflow,
  input wire logic [NUM_PORTS-1:0] i_camera_rx_error,
  input wire logic [NUM_PORTS-1:0] i_link_parity_error,
  input wire logic [NUM_PORTS-1:0] i_port_valid_change,
  input wire logic [NUM_PORTS-1:0] i_lock_change,
  // per-port interrupt request
  output logic [NUM_PORTS-1:0] o_port_int
);
  localparam int SEL_W = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;

  // register state
  logic [7:0] port_sel_q;
  logic [7:0] port_sel_d;
  logic [7:0] icr_high_q [NUM_PORTS];
  logic [7:0] icr_low_q [NUM_PORTS];
  logic [NUM_PORTS-1:0] rise_seen_q;
  logic [NUM_PORTS-1:0] fall_seen_q;
  logic [7:0] rdata_q;
  logic hit_q;
  logic [RXI_NFLAG-1:0] flags [NUM_PORTS];
  logic [SEL_W-1:0] sel_idx;
  logic [NUM_PORTS-1:0] sel_hot;

  // address decode
  wire rd_sts1 = i_reg_rd && (i_reg_addr == RXI_ADDR_PORT_STATUS_ONE);
  wire rd_sts2 = i_reg_rd && (i_reg_addr == RXI_ADDR_PORT_STS2);
  wire rd_cam = i_reg_rd && (i_reg_addr == RXI_ADDR_CAM_STS);
  wire rd_gpio = i_reg_rd && (i_reg_addr == RXI_ADDR_GPIO_STS);
  wire rd_rise = i_reg_rd && (i_reg_addr == RXI_ADDR_SEN_RISE);
  wire rd_fall = i_reg_rd && (i_reg_addr == RXI_ADDR_SEN_FALL);
  wire wr_sel = i_reg_wr && (i_reg_addr == RXI_ADDR_PORT_SEL);
  wire wr_icr_high = i_reg_wr && (i_reg_addr == RXI_ADDR_ICR_HIGH);
  wire wr_icr_low = i_reg_wr && (i_reg_addr == RXI_ADDR_ICR_LOW);

  // selected port, out-of-range indexes reach no port
  assign sel_idx = port_sel_q[SEL_W-1:0]; // RULE14
  assign port_sel_d = wr_sel ? i_reg_wdata : port_sel_q;

  // port select register
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      port_sel_q <= RXI_RST_PORT_SEL;
    end else begin
      port_sel_q <= port_sel_d; // RULE14
    end
  end

  // one flag bank and enable pair per receive port
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      // per-port set and clear vectors
      logic [RXI_NFLAG-1:0] set_vec;
      logic [RXI_NFLAG-1:0] clr_vec;
      logic sel_p;
      logic sen_clr;

      // this port is the one the select register names
      assign sel_p = (32'(sel_idx) == p) && (int'(port_sel_q) < NUM_PORTS);
      assign sel_hot[p] = sel_p;

      // both sensor edge registers read, the second one possibly now
      assign sen_clr = (rise_seen_q[p] || (sel_p && rd_rise))
        && (fall_seen_q[p] || (sel_p && rd_fall)); // RULE2

      // event to flag position
      assign set_vec[RXI_F_LOCK] = i_lock_change[p]; // RULE12
      assign set_vec[RXI_F_VALID] = i_port_valid_change[p]; // RULE11
      assign set_vec[RXI_F_PARITY] = i_link_parity_error[p]; // RULE10
      assign set_vec[RXI_F_CAMERA] = i_camera_rx_error[p]; // RULE9
      assign set_vec[RXI_F_OVERFLOW] = i_rx_overflow[p]; // RULE8
      assign set_vec[RXI_F_LINE_CNT] = i_line_count_change[p]; // RULE7
      assign set_vec[RXI_F_LINE_LEN] = i_line_length_change[p]; // RULE6
      assign set_vec[RXI_F_CRC] = i_ctrl_crc_error[p]; // RULE5
      assign set_vec[RXI_F_SEQ] = i_ctrl_sequence_error[p]; // RULE4
      assign set_vec[RXI_F_ENC] = i_link_encoding_error[p]; // RULE3
      assign set_vec[RXI_F_SENSOR] = i_sensor_change[p]; // RULE2
      assign set_vec[RXI_F_GPIO] = i_fwd_gpio_change[p]; // RULE1

      // clearing reads of the selected port
      assign clr_vec[RXI_F_LOCK] = sel_p && rd_sts1; // RULE12
      assign clr_vec[RXI_F_VALID] = sel_p && rd_sts1; // RULE11
      assign clr_vec[RXI_F_PARITY] = sel_p && rd_sts1; // RULE10
      assign clr_vec[RXI_F_CAMERA] = sel_p && rd_cam; // RULE9
      assign clr_vec[RXI_F_OVERFLOW] = sel_p && rd_sts2; // RULE8
      assign clr_vec[RXI_F_LINE_CNT] = sel_p && rd_sts2; // RULE7
      assign clr_vec[RXI_F_LINE_LEN] = sel_p && rd_sts2; // RULE6
      assign clr_vec[RXI_F_CRC] = sel_p && rd_sts1; // RULE5
      assign clr_vec[RXI_F_SEQ] = sel_p && rd_sts1; // RULE4
      assign clr_vec[RXI_F_ENC] = sel_p && rd_sts2; // RULE3
      assign clr_vec[RXI_F_SENSOR] = sen_clr; // RULE2
      assign clr_vec[RXI_F_GPIO] = sel_p && rd_gpio; // RULE1

      // sticky status bits of this port
      rxi_sticky_flags #(
        .W(RXI_NFLAG)
      ) u_flags (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_set(set_vec),
        .i_clr(clr_vec),
        .o_flags(flags[p])
      );

      // enable registers and sensor read trackers
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          icr_high_q[p] <= RXI_RST_ICR; // RULE13
          icr_low_q[p] <= RXI_RST_ICR; // RULE13
          rise_seen_q[p] <= 1'b0;
          fall_seen_q[p] <= 1'b0;
        end else begin
          if (sel_p && wr_icr_high) begin
            icr_high_q[p] <= i_reg_wdata & RXI_ICR_HIGH_MASK;
          end
          if (sel_p && wr_icr_low) begin
            icr_low_q[p] <= i_reg_wdata & RXI_ICR_LOW_MASK;
          end
          if (sen_clr) begin
            rise_seen_q[p] <= 1'b0;
            fall_seen_q[p] <= 1'b0;
          end else begin
            rise_seen_q[p] <= rise_seen_q[p] || (sel_p && rd_rise);
            fall_seen_q[p] <= fall_seen_q[p] || (sel_p && rd_fall);
          end
        end
      end

      // gpio and sensor bits raise the interrupt with no enable bit
      assign o_port_int[p] =
        |(flags[p][RXI_LOW_W-1:0] & icr_low_q[p][RXI_LOW_W-1:0])
        | |(flags[p][RXI_F_ENC:RXI_F_CRC] & icr_high_q[p][2:0])
        | flags[p][RXI_F_SENSOR] | flags[p][RXI_F_GPIO]; // RULE13
    end
  endgenerate

  // read data mux for the selected port
  logic [7:0] rd_mux;
  logic rd_known;
  always_comb begin
    rd_mux = 8'h00;
    rd_known = 1'b1;
    unique case (i_reg_addr)
      RXI_ADDR_PORT_SEL: rd_mux = port_sel_q;
      RXI_ADDR_ICR_HIGH: rd_known = 1'b1;
      RXI_ADDR_ICR_LOW: rd_known = 1'b1;
      RXI_ADDR_ISR_HIGH: rd_known = 1'b1;
      RXI_ADDR_ISR_LOW: rd_known = 1'b1;
      default: rd_known = 1'b0;
    endcase
    // port-specific registers of the selected port only
    for (int k = 0; k < NUM_PORTS; k++) begin
      if (sel_hot[k]) begin
        if (i_reg_addr == RXI_ADDR_ICR_HIGH) begin
          rd_mux = icr_high_q[k];
        end
        if (i_reg_addr == RXI_ADDR_ICR_LOW) begin
          rd_mux = icr_low_q[k];
        end
        if (i_reg_addr == RXI_ADDR_ISR_HIGH) begin
          rd_mux = {3'h0, flags[k][RXI_NFLAG-1:RXI_LOW_W]};
        end
        if (i_reg_addr == RXI_ADDR_ISR_LOW) begin
          rd_mux = {1'h0, flags[k][RXI_LOW_W-1:0]};
        end
      end
    end
  end

  // registered read answer, one cycle after the read strobe
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_q <= 8'h00;
      hit_q <= 1'b0;
    end else if (i_reg_rd) begin
      rdata_q <= rd_known ? rd_mux : 8'h00;
      hit_q <= rd_known;
    end
  end

  // registered read outputs
  assign o_reg_rdata = rdata_q;
  assign o_reg_hit = hit_q;
endmodule

// file: tb/rxi_port_int_status_assertions.sv
`timescale 1ns/100ps
module rxi_port_int_status_assertions #(
  parameter int NUM_PORTS = 2
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_hit,
  input wire logic [NUM_PORTS-1:0] o_port_int
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // addresses owned by this block
  wire own = i_reg_addr inside {8'h4c, 8'hd8, 8'hd9, 8'hda, 8'hdb};
  sequence sel_wr; i_reg_wr && !i_reg_rd && i_reg_addr == 8'h4c; endsequence
  sequence sel_rd; i_reg_rd && !i_reg_wr && i_reg_addr == 8'h4c; endsequence
  AST_UNMAPPED: assert property (i_reg_rd && !own |=> o_reg_rdata == 8'h00 && !o_reg_hit)
    else $error("foreign read not empty");
  AST_HIT: assert property (i_reg_rd && own |=> o_reg_hit)
    else $error("owned read without hit");
  AST_HIGH_EN_RSVD: assert property (i_reg_rd && i_reg_addr == 8'hd8 |=> o_reg_rdata[7:3] == 5'h00)
    else $error("high enable spare bits set");
  AST_LOW_EN_RSVD: assert property (i_reg_rd && i_reg_addr == 8'hd9 |=> !o_reg_rdata[7])
    else $error("low enable spare bit set");
  AST_HIGH_RSVD: assert property (i_reg_rd && i_reg_addr == 8'hda |=> o_reg_rdata[7:5] == 3'h0)
    else $error("high status spare bits set");
  AST_LOW_RSVD: assert property (i_reg_rd && i_reg_addr == 8'hdb |=> !o_reg_rdata[7])
    else $error("low status spare bit set");
  AST_SEL_READBACK: assert property (sel_wr ##1 sel_rd |=> o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("port select readback wrong");
  AST_RESET_CLEAN: assert property ($fell(i_srst) |-> o_port_int == '0 && !o_reg_hit)
    else $error("outputs not clear after reset");
  AST_STICKY: assert property (!i_reg_rd && !i_reg_wr |=> (o_port_int & $past(o_port_int)) == $past(o_port_int))
    else $error("interrupt dropped without access");
endmodule

// file: tb/rxi_port_int_status_bench.sv
`timescale 1ns/100ps
module rxi_port_int_status_bench import rxi_pkg::*;;
  logic i_clk = 1'b0, i_srst = 1'b1, rd = 1'b0, wr = 1'b0, hit, exh, rv, v, p;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata, ex, sel, na, nw;
  logic [7:0] eh [2], el [2];
  logic [7:0] tbl [12] = '{8'h4c, 8'h4d, 8'h4e, 8'h7a, 8'hd8, 8'hd9, 8'hda, 8'hdb,
    8'hdc, 8'hde, 8'hdf, 8'h31};
  logic [17:0] dir [6] = '{{2'd1, 8'hd9, 8'hff}, {2'd0, 8'hd9, 8'h00}, {2'd1, 8'hda, 8'hff},
    {2'd0, 8'hda, 8'h00}, {2'd1, 8'h4c, 8'h07}, {2'd0, 8'h4c, 8'h00}};
  logic [23:0] ev = '0;
  logic [11:0] fl [2], cm;
  logic [1:0] pint, op;
  logic sr [2], sf [2];
  int n_fail = 0, checks = 0, cyc = 0, ticks = 0;
  always #5 i_clk = ~i_clk;
  rxi_port_int_status #(.NUM_PORTS(2)) rxi_port_int_status_inst (.i_clk(i_clk),
    .i_srst(i_srst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd),
    .o_reg_rdata(rdata), .o_reg_hit(hit), .o_port_int(pint),
    .i_fwd_gpio_change(ev[2*RXI_F_GPIO+:2]), .i_sensor_change(ev[2*RXI_F_SENSOR+:2]),
    .i_link_encoding_error(ev[2*RXI_F_ENC+:2]), .i_ctrl_sequence_error(ev[2*RXI_F_SEQ+:2]),
    .i_ctrl_crc_error(ev[2*RXI_F_CRC+:2]), .i_line_length_change(ev[2*RXI_F_LINE_LEN+:2]),
    .i_line_count_change(ev[2*RXI_F_LINE_CNT+:2]), .i_rx_overflow(ev[2*RXI_F_OVERFLOW+:2]),
    .i_camera_rx_error(ev[2*RXI_F_CAMERA+:2]), .i_link_parity_error(ev[2*RXI_F_PARITY+:2]),
    .i_port_valid_change(ev[2*RXI_F_VALID+:2]), .i_lock_change(ev[2*RXI_F_LOCK+:2]));
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (n_fail == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // flags wiped by a clearing read, sensor bit apart
  function automatic logic [11:0] clr_of(input logic [7:0] a);
    case (a)
      8'h4d: return 12'h187;
      8'h4e: return 12'h270;
      8'h7a: return 12'h008;
      8'hdc: return 12'h800;
      default: return 12'h000;
    endcase
  endfunction
  // hit and data of a read
  function automatic logic [8:0] rd_of(input logic [7:0] a, s, input logic [11:0] f,
    input logic [7:0] h, l);
    logic ok;
    ok = s < 8'h02;
    case (a)
      8'h4c: return {1'b1, s};
      8'hd8: return {1'b1, ok ? h : 8'h00};
      8'hd9: return {1'b1, ok ? l : 8'h00};
      8'hda: return {1'b1, ok ? {3'h0, f[11:7]} : 8'h00};
      8'hdb: return {1'b1, ok ? {1'b0, f[6:0]} : 8'h00};
      default: return 9'h000;
    endcase
  endfunction
  // enabled flags of one port
  function automatic logic int_of(input logic [11:0] f, input logic [7:0] h, l);
    return |(f & {2'b11, h[2:0], l[6:0]});
  endfunction
  // cycle ceiling
  always @(posedge i_clk) begin
    ticks++;
    if (ticks > 7000) begin
      n_fail++;
      results();
    end
  end
  // model each edge, then drive the next cycle
  initial begin
    void'($urandom(84210));
    repeat (6000) begin
      @(posedge i_clk);
      rv = 1'b1;
      {exh, ex} = 9'h000;
      if (i_srst) begin
        foreach (fl[q]) begin
          {fl[q], eh[q], el[q], sr[q], sf[q]} = '0;
        end
        sel = 8'h00;
      end else begin
        rv = rd;
        p = sel[0];
        v = sel < 8'h02;
        if (rd)
          {exh, ex} = rd_of(addr, sel, fl[p], eh[p], el[p]);
        cm = (rd && v) ? clr_of(addr) : 12'h000;
        if (rd && v) begin
          sr[p] = sr[p] | (addr == 8'hde);
          sf[p] = sf[p] | (addr == 8'hdf);
          if (sr[p] && sf[p]) begin
            cm[RXI_F_SENSOR] = 1'b1;
            {sr[p], sf[p]} = 2'b00;
          end
        end
        if (wr && v && addr == 8'hd8)
          eh[p] = wd & 8'h07;
        if (wr && v && addr == 8'hd9)
          el[p] = wd & 8'h7f;
        if (wr && addr == 8'h4c)
          sel = wd;
        foreach (fl[q])
          for (int f = 0; f < 12; f++)
            fl[q][f] = (fl[q][f] & !(q == p && cm[f])) | ev[2*f+q];
      end
      cyc++;
      i_srst <= cyc < 4 || (cyc >= 3000 && cyc < 3002);
      na = tbl[$urandom % 12];
      op = 2'($urandom % 3);
      nw = (na == 8'h4c) ? 8'($urandom % 3) : 8'($urandom);
      if (cyc >= 4 && cyc < 10)
        {op, na, nw} = dir[cyc-4];
      rd <= op == 2'd0;
      wr <= op == 2'd1;
      addr <= na;
      wd <= nw;
      foreach (ev[b])
        ev[b] <= ($urandom % (cyc[9] ? 400 : 30)) == 0;
      #1;
      if (rv)
        check(12'({hit, rdata}), 12'({exh, ex}));
      check(12'(pint), 12'({int_of(fl[1], eh[1], el[1]), int_of(fl[0], eh[0], el[0])}));
    end
    results();
  end
endmodule
bind rxi_port_int_status rxi_port_int_status_assertions #(.NUM_PORTS(NUM_PORTS))
  rxi_port_int_status_assertions_inst (.i_clk(i_clk), .i_srst(i_srst), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .o_reg_hit(o_reg_hit), .o_port_int(o_port_int));
